// >>> masked_reset_reg.sv
// one capability-masked software reset control register
`timescale 1ns/1ps
`include "reset_ctrl_cfg.svh"

module masked_reset_reg #(
    parameter reset_ctrl_pkg::word_t IMPL = 32'h00000000
) (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  write_en,
    input  wire logic [3:0]            write_strb,
    input  wire reset_ctrl_pkg::word_t write_data,
    input  wire reset_ctrl_pkg::word_t capability,
    output reset_ctrl_pkg::word_t      value
);
    reset_ctrl_pkg::word_t lane_mask;
    reset_ctrl_pkg::word_t write_mask;

    always_comb begin
        lane_mask = {{8{write_strb[3]}}, {8{write_strb[2]}},
                     {8{write_strb[1]}}, {8{write_strb[0]}}};
        // absent units and reserved bits never take a write
        write_mask = lane_mask & capability & IMPL;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            value <= `RESET_CTRL_RESET_VALUE;
        end else if (write_en) begin
            value <= (value & ~write_mask)
                   | (write_data & write_mask);
        end
    end

    AST_RESERVED_ZERO: assert property (@(posedge clk)
        disable iff (!reset_n)
        (value & ~IMPL) == 32'h00000000)
        else $error("reserved reset bit set");
    AST_ABSENT_UNIT: assert property (@(posedge clk)
        disable iff (!reset_n)
        write_en && (write_mask == 32'h00000000) |=> $stable(value))
        else $error("masked write changed register");
endmodule

// >>> peripheral_soft_reset_control.sv
// AXI4-Lite slave holding the two peripheral software reset registers
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "reset_ctrl_cfg.svh"

module peripheral_soft_reset_control (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    // capability masks from the system control block
    input  wire reset_ctrl_pkg::word_t capability_mask_two,
    input  wire reset_ctrl_pkg::word_t capability_mask_four,
    // axi4-lite slave
    input  wire logic [31:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [31:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // unit resets, high holds the unit in reset
    output logic                       comparator_one_reset_bit,
    output logic                       comparator_zero_reset_bit,
    output logic                       gp_counter_two_reset_bit,
    output logic                       gp_counter_one_reset_bit,
    output logic                       gp_counter_zero_reset_bit,
    output logic                       sync_serial_zero_reset_bit,
    output logic                       async_serial_zero_reset_bit,
    output logic                       ethernet_phy_reset_bit,
    output logic                       ethernet_mac_reset_bit,
    output logic [6:0]                 io_port_reset_bits
);
    // ------------------------------------------------------------
    // write channel capture
    // ------------------------------------------------------------
    logic                  aw_held;
    logic                  w_held;
    reset_ctrl_pkg::offset_t aw_offset;
    reset_ctrl_pkg::word_t w_data;
    logic [3:0]            w_strb;
    logic                  do_write;
    reset_ctrl_pkg::reg_sel_t wr_sel;
    reset_ctrl_pkg::reg_sel_t rd_sel;
    reset_ctrl_pkg::word_t ctrl_one;
    reset_ctrl_pkg::word_t ctrl_two;

    // address and data may come in either order; one write at a time
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    function automatic reset_ctrl_pkg::reg_sel_t decode(
        input logic [11:0] offset
    );
        if (offset == `RESET_CTRL_ONE_OFFSET) begin
            decode = reset_ctrl_pkg::SEL_ONE;
        end else if (offset == `RESET_CTRL_TWO_OFFSET) begin
            decode = reset_ctrl_pkg::SEL_TWO;
        end else begin
            decode = reset_ctrl_pkg::SEL_NONE;
        end
    endfunction

    assign wr_sel = decode(aw_offset);
    // byte lanes of the read address are ignored, as on the write side
    assign rd_sel = decode({s_axi_araddr[11:2], 2'b00});

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            aw_held       <= 1'b0;
            aw_offset     <= 12'h000;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awready && s_axi_awvalid) begin
            aw_held       <= 1'b1;
            aw_offset     <= {s_axi_awaddr[11:2], 2'b00};
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_held       <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            w_held       <= 1'b0;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wready && s_axi_wvalid) begin
            w_held       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_held       <= 1'b0;
        end else begin
            s_axi_wready <= !w_held && !s_axi_bvalid;
        end
    end

    // ------------------------------------------------------------
    // write response
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `AXI_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_sel == reset_ctrl_pkg::SEL_NONE)
                          ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // the two registers
    // ------------------------------------------------------------
    masked_reset_reg #(
        .IMPL (`RESET_CTRL_ONE_IMPL)
    ) u_ctrl_one (
        .clk        (clk),
        .reset_n    (reset_n),
        .write_en   (do_write && wr_sel == reset_ctrl_pkg::SEL_ONE),
        .write_strb (w_strb),
        .write_data (w_data),
        .capability (capability_mask_two),
        .value      (ctrl_one)
    );

    masked_reset_reg #(
        .IMPL (`RESET_CTRL_TWO_IMPL)
    ) u_ctrl_two (
        .clk        (clk),
        .reset_n    (reset_n),
        .write_en   (do_write && wr_sel == reset_ctrl_pkg::SEL_TWO),
        .write_strb (w_strb),
        .write_data (w_data),
        .capability (capability_mask_four),
        .value      (ctrl_two)
    );

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid
                          && s_axi_arvalid;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `AXI_RESP_OKAY;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            unique case (rd_sel)
                reset_ctrl_pkg::SEL_ONE: begin
                    s_axi_rdata <= ctrl_one;
                    s_axi_rresp <= `AXI_RESP_OKAY;
                end
                reset_ctrl_pkg::SEL_TWO: begin
                    s_axi_rdata <= ctrl_two;
                    s_axi_rresp <= `AXI_RESP_OKAY;
                end
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `AXI_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // unit reset outputs, registered so they are glitch free
    // ------------------------------------------------------------
    // costs one cycle of latency between write and unit reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            comparator_one_reset_bit    <= 1'b0;
            comparator_zero_reset_bit   <= 1'b0;
            gp_counter_two_reset_bit    <= 1'b0;
            gp_counter_one_reset_bit    <= 1'b0;
            gp_counter_zero_reset_bit   <= 1'b0;
            sync_serial_zero_reset_bit  <= 1'b0;
            async_serial_zero_reset_bit <= 1'b0;
            ethernet_phy_reset_bit      <= 1'b0;
            ethernet_mac_reset_bit      <= 1'b0;
            io_port_reset_bits          <= 7'h00;
        end else begin
            comparator_one_reset_bit    <= ctrl_one[`COMPARATOR_ONE_BIT];
            comparator_zero_reset_bit   <= ctrl_one[`COMPARATOR_ZERO_BIT];
            gp_counter_two_reset_bit    <= ctrl_one[`GP_COUNTER_TWO_BIT];
            gp_counter_one_reset_bit    <= ctrl_one[`GP_COUNTER_ONE_BIT];
            gp_counter_zero_reset_bit   <= ctrl_one[`GP_COUNTER_ZERO_BIT];
            sync_serial_zero_reset_bit  <= ctrl_one[`SYNC_SERIAL_ZERO_BIT];
            async_serial_zero_reset_bit <= ctrl_one[`ASYNC_SERIAL_ZERO_BIT];
            ethernet_phy_reset_bit      <= ctrl_two[`ETHERNET_PHY_BIT];
            ethernet_mac_reset_bit      <= ctrl_two[`ETHERNET_MAC_BIT];
            io_port_reset_bits <= ctrl_two[`IO_PORT_MSB:`IO_PORT_LSB];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence write_one_s;
        do_write && wr_sel == reset_ctrl_pkg::SEL_ONE && w_strb[3];
    endsequence

    // a write that hits no register must leave both registers alone
    sequence unmapped_write_s;
        do_write && wr_sel == reset_ctrl_pkg::SEL_NONE;
    endsequence

    // the master has not yet taken the write response
    sequence response_waiting_s;
        s_axi_bvalid && !s_axi_bready;
    endsequence

    AST_COMP_ONE: assert property (@(posedge clk)
        disable iff (!reset_n)
        write_one_s ##0 capability_mask_two[25] |=>
        ##1 comparator_one_reset_bit == $past(w_data[25], 2))
        else $error("comparator one reset wrong");
    AST_COMP_ZERO: assert property (@(posedge clk)
        disable iff (!reset_n)
        ##1 comparator_zero_reset_bit == $past(ctrl_one[24]))
        else $error("comparator zero reset wrong");
    AST_COUNTERS: assert property (@(posedge clk)
        disable iff (!reset_n)
        ##1 {gp_counter_two_reset_bit, gp_counter_one_reset_bit,
         gp_counter_zero_reset_bit} == $past(ctrl_one[18:16]))
        else $error("counter resets wrong");
    AST_SERIAL: assert property (@(posedge clk)
        disable iff (!reset_n)
        ##1 {sync_serial_zero_reset_bit, async_serial_zero_reset_bit}
        == $past({ctrl_one[4], ctrl_one[0]}))
        else $error("serial resets wrong");
    AST_ETHERNET: assert property (@(posedge clk)
        disable iff (!reset_n)
        ##1 {ethernet_phy_reset_bit, ethernet_mac_reset_bit}
        == $past({ctrl_two[30], ctrl_two[28]}))
        else $error("ethernet resets wrong");
    AST_IO_PORTS: assert property (@(posedge clk)
        disable iff (!reset_n)
        ##1 io_port_reset_bits == $past(ctrl_two[6:0]))
        else $error("io port resets wrong");
    AST_MASK_TWO: assert property (@(posedge clk)
        disable iff (!reset_n)
        do_write && wr_sel == reset_ctrl_pkg::SEL_ONE |=>
        ((ctrl_one ^ $past(ctrl_one)) & ~$past(capability_mask_two))
        == 32'h00000000)
        else $error("capability two mask ignored");
    AST_MASK_FOUR: assert property (@(posedge clk)
        disable iff (!reset_n)
        do_write && wr_sel == reset_ctrl_pkg::SEL_TWO |=>
        ((ctrl_two ^ $past(ctrl_two)) & ~$past(capability_mask_four))
        == 32'h00000000)
        else $error("capability four mask ignored");
    AST_RESET_ZERO: assert property (@(posedge clk)
        !reset_n |=> ctrl_one == 32'h00000000
        && ctrl_two == 32'h00000000)
        else $error("registers not zero after reset");
    AST_RESERVED_TWO: assert property (@(posedge clk)
        disable iff (!reset_n)
        (ctrl_two & ~`RESET_CTRL_TWO_IMPL) == 32'h00000000)
        else $error("reserved bit of second register set");
    AST_READ_RESP: assert property (@(posedge clk)
        disable iff (!reset_n)
        s_axi_arready && s_axi_arvalid |=> s_axi_rvalid)
        else $error("read not answered");
    AST_UNMAPPED_WRITE: assert property (@(posedge clk)
        disable iff (!reset_n)
        unmapped_write_s |=> s_axi_bresp == `AXI_RESP_SLVERR
        && $stable(ctrl_one) && $stable(ctrl_two))
        else $error("unmapped write not refused");
    AST_BVALID_HOLD: assert property (@(posedge clk)
        disable iff (!reset_n)
        response_waiting_s |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_RVALID_HOLD: assert property (@(posedge clk)
        disable iff (!reset_n)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata))
        else $error("read response dropped early");
endmodule

// >>> peripheral_soft_reset_control_bench.sv
// self-checking bench for the peripheral software reset registers
`timescale 1ns/1ps
`include "reset_ctrl_cfg.svh"

module peripheral_soft_reset_control_bench;
    typedef struct packed {
        logic [11:0] off;
        logic [31:0] data;
        logic [3:0]  strb;
        logic [31:0] cap;
    } row_t;

    logic        clk;
    logic        reset_n;
    logic [31:0] capability_mask_two;
    logic [31:0] capability_mask_four;
    logic [31:0] s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [31:0] s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic        cmp1, cmp0, tm2, tm1, tm0, ssi, uart, phy, mac;
    logic [6:0]  ports;
    logic [31:0] out_one, out_two, rd, model [2];
    logic [1:0]  resp;
    int          miscompares, comparisons;
    row_t        rows [9];

    assign out_one = {6'h00, cmp1, cmp0, 5'h00, tm2, tm1, tm0,
                      11'h000, ssi, 3'h0, uart};
    assign out_two = {1'b0, phy, 1'b0, mac, 21'h000000, ports};

    peripheral_soft_reset_control dut (
        .clk(clk), .reset_n(reset_n),
        .capability_mask_two(capability_mask_two),
        .capability_mask_four(capability_mask_four),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .comparator_one_reset_bit(cmp1), .comparator_zero_reset_bit(cmp0),
        .gp_counter_two_reset_bit(tm2), .gp_counter_one_reset_bit(tm1),
        .gp_counter_zero_reset_bit(tm0), .sync_serial_zero_reset_bit(ssi),
        .async_serial_zero_reset_bit(uart), .ethernet_phy_reset_bit(phy),
        .ethernet_mac_reset_bit(mac), .io_port_reset_bits(ports)
    );

    // ----------------------------------------
    // clock, checks and closing
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    task automatic summarize;
        $display("comparisons %0d miscompares %0d", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // axi4-lite master tasks
    // ----------------------------------------
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        bit aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // both registers and all unit outputs against the model
    task automatic check_all;
        axi_read(`CTRL_BLOCK_BASE + 32'h044, rd, resp);
        check(rd, model[0]);
        check({30'h0, resp}, {30'h0, `AXI_RESP_OKAY});
        axi_read(`CTRL_BLOCK_BASE + 32'h048, rd, resp);
        check(rd, model[1]);
        check(out_one, model[0]);
        check(out_two, model[1]);
    endtask

    task automatic apply_reset;
        reset_n <= 1'b0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        model[0] = 32'h00000000;
        model[1] = 32'h00000000;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        summarize();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] lanes, mask;
        int k;
        reset_n = 1'b0;
        capability_mask_two = 32'hffffffff;
        capability_mask_four = 32'hffffffff;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'h0;
        miscompares = 0;
        comparisons = 0;
        rows = '{'{12'h044, 32'hffffffff, 4'hf, 32'hffffffff},
                 '{12'h048, 32'hffffffff, 4'hf, 32'hffffffff},
                 '{12'h044, 32'h00000000, 4'hf, 32'hfffffffe},
                 '{12'h048, 32'h00000000, 4'hf, 32'h0000007f},
                 '{12'h044, 32'h00000000, 4'h1, 32'hffffffff},
                 '{12'h048, 32'h12345678, 4'hf, 32'hffffffff},
                 '{12'h044, 32'h02010010, 4'hf, 32'hffffffff},
                 '{12'h048, 32'h00000000, 4'hf, 32'hffffffff},
                 '{12'h044, 32'h00000000, 4'hf, 32'hffffffff}};
        apply_reset();
        check_all();
        $display("test reset values done");
        for (int i = 0; i < 9; i++) begin
            k = (rows[i].off == 12'h048) ? 1 : 0;
            capability_mask_two <= rows[i].cap;
            capability_mask_four <= rows[i].cap;
            for (int b = 0; b < 4; b++) begin
                lanes[b*8 +: 8] = {8{rows[i].strb[b]}};
            end
            mask = rows[i].cap & lanes &
                   (k ? `RESET_CTRL_TWO_IMPL : `RESET_CTRL_ONE_IMPL);
            // absent units and reserved bits keep their old value
            model[k] = (model[k] & ~mask) | (rows[i].data & mask);
            axi_write(`CTRL_BLOCK_BASE + {20'h00000, rows[i].off},
                      rows[i].data, rows[i].strb, resp);
            check({30'h0, resp}, {30'h0, `AXI_RESP_OKAY});
            check_all();
            $display("test row %0d done", i);
        end
        // unmapped offset just below the first register
        axi_write(`CTRL_BLOCK_BASE + 32'h040, 32'hffffffff, 4'hf, resp);
        check({30'h0, resp}, {30'h0, `AXI_RESP_SLVERR});
        axi_read(`CTRL_BLOCK_BASE + 32'h040, rd, resp);
        check({30'h0, resp}, {30'h0, `AXI_RESP_SLVERR});
        check(rd, 32'h00000000);
        check_all();
        $display("test unmapped offset done");
        // software read-modify-write writes reserved bits back as read
        axi_read(`CTRL_BLOCK_BASE + 32'h048, rd, resp);
        check(rd, model[1]);
        axi_write(`CTRL_BLOCK_BASE + 32'h048, rd | 32'h00000004, 4'hf,
                  resp);
        model[1] = model[1] | 32'h00000004;
        check({30'h0, resp}, {30'h0, `AXI_RESP_OKAY});
        check_all();
        $display("test read-modify-write done");
        // second reset in mid-run with units held in reset
        axi_write(`CTRL_BLOCK_BASE + 32'h044, 32'hffffffff, 4'hf, resp);
        axi_write(`CTRL_BLOCK_BASE + 32'h048, 32'hffffffff, 4'hf, resp);
        apply_reset();
        @(posedge clk);
        check(out_one, 32'h00000000);
        check(out_two, 32'h00000000);
        check_all();
        $display("test mid-run reset done");
        summarize();
    end
endmodule

// >>> reset_ctrl_cfg.svh
// offsets, field positions, masks and reset values of the reset control
`ifndef RESET_CTRL_CFG_SVH
`define RESET_CTRL_CFG_SVH

`define CTRL_BLOCK_BASE        32'h400fe000
`define RESET_CTRL_ONE_OFFSET  12'h044
`define RESET_CTRL_TWO_OFFSET  12'h048
`define RESET_CTRL_RESET_VALUE 32'h00000000

// implemented bits of the first register
`define COMPARATOR_ONE_BIT     25
`define COMPARATOR_ZERO_BIT    24
`define GP_COUNTER_TWO_BIT     18
`define GP_COUNTER_ONE_BIT     17
`define GP_COUNTER_ZERO_BIT    16
`define SYNC_SERIAL_ZERO_BIT   4
`define ASYNC_SERIAL_ZERO_BIT  0
`define RESET_CTRL_ONE_IMPL    32'h03070011

// implemented bits of the second register
`define ETHERNET_PHY_BIT       30
`define ETHERNET_MAC_BIT       28
`define IO_PORT_LSB            0
`define IO_PORT_MSB            6
`define RESET_CTRL_TWO_IMPL    32'h5000007f

`define AXI_RESP_OKAY          2'b00
`define AXI_RESP_SLVERR        2'b10

`endif

// >>> reset_ctrl_pkg.sv
// types shared by the reset control files
package reset_ctrl_pkg;
    typedef logic [31:0] word_t;
    typedef logic [11:0] offset_t;
    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_ONE  = 2'b01,
        SEL_TWO  = 2'b10
    } reg_sel_t;
endpackage
